// File: sbt_channel.sv
// sbt_channel: baud generator, term-char detector, idle fill and crc options of one channel
// assumes rx characters arrive as one-cycle strobes and the selected clock source
// arrives as a one-cycle enable in the mclk domain
module sbt_channel
  import sbt_pkg::*;
#(
  parameter int DIV_W = 21
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clk_src_tick,
  input wire sbt_mode_t op_mode,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic tx_busy,
  output logic brg_tick,
  output logic rx_block_end,
  output logic idle_line,
  output logic rx_crc_check,
  output logic tx_crc_append,
  output sbt_cfg2_t cfg2_out,
  output logic irq
);

  // the divisor arithmetic below is sized for a 21-bit field only
  if (DIV_W != 21)
  begin : g_bad_div_w
    $error("sbt_channel: divisor field is 21 bits");
  end

  logic [31:0] baud_divisor_ff;
  logic [31:0] term_char_config_ff;
  logic [31:0] channel_config_second_ff;
  logic [31:0] istat_ff;
  logic [31:0] imask_ff;
  logic [11:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [31:0] wm);
    logic [31:0] bm;
    bm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wm;
    merge = (old & ~bm) | (wd & bm);
  endfunction

  // write channels taken in either order; response after both
  wire do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  wire [11:0] wa = {awaddr_ff[11:2], 2'b00};
  wire wa_hit = (wa == SBT_OFF_BAUD) || (wa == SBT_OFF_TERM) || (wa == SBT_OFF_CFG2) ||
                (wa == SBT_OFF_ISTAT) || (wa == SBT_OFF_IMASK);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SBT_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wa_hit ? SBT_RESP_OKAY : SBT_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // write masks keep reserved bits at zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      baud_divisor_ff <= SBT_RESET_VAL;
      term_char_config_ff <= SBT_RESET_VAL;
      channel_config_second_ff <= SBT_RESET_VAL;
      imask_ff <= SBT_RESET_VAL;
    end
    else if (do_write)
    begin
      if (wa == SBT_OFF_BAUD)
        baud_divisor_ff <= merge(baud_divisor_ff, wdata_ff, wstrb_ff, SBT_BAUD_WMASK);
      if (wa == SBT_OFF_TERM)
        term_char_config_ff <= merge(term_char_config_ff, wdata_ff, wstrb_ff, SBT_TERM_WMASK);
      if (wa == SBT_OFF_CFG2)
        channel_config_second_ff <= merge(channel_config_second_ff, wdata_ff, wstrb_ff, SBT_CFG2_WMASK);
      if (wa == SBT_OFF_IMASK)
        imask_ff <= merge(imask_ff, wdata_ff, wstrb_ff, SBT_INT_WMASK);
    end
  end

  // read channel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= SBT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= SBT_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        SBT_OFF_BAUD: s_axi_rdata <= baud_divisor_ff;
        SBT_OFF_TERM: s_axi_rdata <= term_char_config_ff;
        SBT_OFF_CFG2: s_axi_rdata <= channel_config_second_ff;
        SBT_OFF_ISTAT: s_axi_rdata <= istat_ff;
        SBT_OFF_IMASK: s_axi_rdata <= imask_ff;
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= SBT_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // divisor k minus one, so the counter reloads with no adder in the loop
  logic [DIV_W+15:0] k_minus1;
  logic [DIV_W+15:0] brg_cnt_ff;
  always_comb
  begin
    if (baud_divisor_ff[SBT_FORM_BIT])
      k_minus1 = {16'h0000, baud_divisor_ff[SBT_DIV_MSB:0]};
    else
      k_minus1 = (({{(DIV_W+10){1'b0}}, baud_divisor_ff[SBT_N_MSB:0]} + 37'h1)
                  << baud_divisor_ff[SBT_M_MSB:SBT_M_LSB]) - 37'h1;
  end

  // counts only on ticks of the selected source, so f_out = f_in / k
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      brg_cnt_ff <= '0;
      brg_tick <= 1'b0;
    end
    else
    begin
      brg_tick <= 1'b0;
      if (clk_src_tick)
      begin
        if (brg_cnt_ff >= k_minus1)
        begin
          brg_cnt_ff <= '0;
          brg_tick <= 1'b1;
        end
        else
          brg_cnt_ff <= brg_cnt_ff + 37'h1;
      end
    end
  end

  // termination character detection
  wire term_mode_ok = (op_mode == SBT_MODE_ASYNC) || (op_mode == SBT_MODE_ISOCHR);
  wire term_hit = rx_char_valid && term_mode_ok && term_char_config_ff[SBT_TERM_EN_BIT]
                  && (rx_char == term_char_config_ff[SBT_CHAR_MSB:0]);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rx_block_end <= 1'b0;
    else
      rx_block_end <= term_hit;
  end

  // sticky status; a new hit wins over a write-one clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      istat_ff <= SBT_RESET_VAL;
    else if (term_hit)
      istat_ff[SBT_INT_TERM_BIT] <= 1'b1;
    else if (do_write && wa == SBT_OFF_ISTAT && wstrb_ff[0] && wdata_ff[SBT_INT_TERM_BIT])
      istat_ff[SBT_INT_TERM_BIT] <= 1'b0;
  end

  // mask bit 1 blocks, so irq rises only for unmasked status bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(istat_ff & ~imask_ff & SBT_INT_WMASK);
  end

  // idle line fill: ones or a rotating flag pattern
  logic [2:0] flag_pos_ff;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flag_pos_ff <= 3'h0;
      idle_line <= 1'b1;
    end
    else if (tx_busy)
    begin
      flag_pos_ff <= 3'h0;
      idle_line <= 1'b1;
    end
    else if (brg_tick)
    begin
      flag_pos_ff <= flag_pos_ff + 3'h1;
      idle_line <= channel_config_second_ff[SBT_IDLE_FILL_BIT] ? SBT_FLAG_PATTERN[flag_pos_ff] : 1'b1;
    end
  end

  // crc options apply in hdlc mode only
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_crc_check <= 1'b0;
      tx_crc_append <= 1'b0;
      cfg2_out <= '0;
    end
    else
    begin
      rx_crc_check <= (op_mode == SBT_MODE_HDLC) && !channel_config_second_ff[SBT_RX_CRC_DIS_BIT];
      tx_crc_append <= (op_mode == SBT_MODE_HDLC) && !channel_config_second_ff[SBT_TX_CRC_BIT];
      cfg2_out <= '{idle_flags: channel_config_second_ff[SBT_IDLE_FILL_BIT],
                    rx_crc_disable: channel_config_second_ff[SBT_RX_CRC_DIS_BIT],
                    tx_crc_off: channel_config_second_ff[SBT_TX_CRC_BIT],
                    rx_status_format: channel_config_second_ff[SBT_RX_FMT_BIT],
                    rx_threshold: channel_config_second_ff[SBT_RX_THR_BIT]};
    end
  end

endmodule

// File: sbt_channel_sva.sv
// sbt_channel_sva: port-level checks for sbt_channel
// assumes one mclk domain with an active-high async rst
module sbt_channel_sva
  import sbt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic clk_src_tick,
  input wire sbt_mode_t op_mode,
  input wire logic rx_char_valid,
  input wire logic brg_tick,
  input wire logic rx_block_end,
  input wire logic idle_line,
  input wire logic rx_crc_check,
  input wire logic tx_crc_append,
  input wire sbt_cfg2_t cfg2_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  AST_BRG_SRC: assert property (brg_tick |-> $past(clk_src_tick))
    else $error("brg tick without source edge");
  AST_BEND: assert property (rx_block_end |-> $past(rx_char_valid) && $past(op_mode) != SBT_MODE_HDLC)
    else $error("block end without async char");
  AST_RX_CRC: assert property ((op_mode == SBT_MODE_HDLC && !cfg2_out.rx_crc_disable) [*3] |-> rx_crc_check)
    else $error("rx crc check missing");
  AST_TX_CRC: assert property ((op_mode == SBT_MODE_HDLC && !cfg2_out.tx_crc_off) [*3] |-> tx_crc_append)
    else $error("tx crc append missing");
  AST_CRC_OFF: assert property ((op_mode != SBT_MODE_HDLC) [*3] |-> !rx_crc_check && !tx_crc_append)
    else $error("crc active outside hdlc");
  AST_IDLE_ONES: assert property (!cfg2_out.idle_flags && brg_tick ##1 !cfg2_out.idle_flags [*2] |-> idle_line)
    else $error("idle line not high");
endmodule
bind sbt_channel sbt_channel_sva u_sva (.mclk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .clk_src_tick, .op_mode, .rx_char_valid, .brg_tick, .rx_block_end, .idle_line, .rx_crc_check,
  .tx_crc_append, .cfg2_out);

// File: sbt_line_model.sv
// sbt_line_model: far-side line giving clock-source edges and rx characters
// assumes the bench enables edges and calls send_char from one process
module sbt_line_model
(
  input wire logic mclk,
  input wire logic tick_en,
  output logic clk_src_tick,
  output logic [7:0] rx_char,
  output logic rx_char_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rx_char = 8'hA5;
    rx_char_valid = 1'b0;
  end
  // irregular edges prove the divider counts source edges, not mclk
  always @(posedge mclk)
    clk_src_tick <= tick_en && $urandom_range(1, 0);
  task automatic send_char(input logic [7:0] c);
    @(posedge mclk);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge mclk);
    rx_char_valid <= 1'b0;
    // released data never repeats the last value
    rx_char <= ~c;
  endtask
endmodule

// File: sbt_pkg.sv
// sbt_pkg: constants and carrier types for the serial channel baud/term-char block
// assumes an AXI4-Lite master with 32-bit data and a 100 MHz mclk
// Behaviour
// - bit 31 selects legacy or direct divisor
// - generator output is input clock over k
// - legacy k = (N+1) times 2^M
// - direct k = 21-bit field plus one
// - generator clocked by selected channel clock source
// - reserved bits read zero, ignore writes
// - detection disabled means no comparison
// - match gives block end and interrupt
// - eight-bit term character compared when enabled
// - detection only in async and isochronous modes
// - idle fill: ones or back-to-back flags
package sbt_pkg;
  localparam logic [11:0] SBT_OFF_BAUD = 12'h12C;
  localparam logic [11:0] SBT_OFF_TERM = 12'h148;
  localparam logic [11:0] SBT_OFF_CFG2 = 12'h14C;
  localparam logic [11:0] SBT_OFF_ISTAT = 12'h150;
  localparam logic [11:0] SBT_OFF_IMASK = 12'h154;
  localparam logic [31:0] SBT_BAUD_WMASK = 32'h801FFFFF;
  localparam logic [31:0] SBT_TERM_WMASK = 32'h000080FF;
  localparam logic [31:0] SBT_CFG2_WMASK = 32'h004C0009;
  localparam logic [31:0] SBT_RESET_VAL = 32'h00000000;
  localparam logic [31:0] SBT_INT_WMASK = 32'h00000001;
  localparam int SBT_FORM_BIT = 31;
  localparam int SBT_TERM_EN_BIT = 15;
  localparam int SBT_IDLE_FILL_BIT = 3;
  localparam int SBT_TX_CRC_BIT = 0;
  localparam int SBT_RX_CRC_DIS_BIT = 22;
  localparam int SBT_RX_FMT_BIT = 19;
  localparam int SBT_RX_THR_BIT = 18;
  localparam int SBT_DIV_MSB = 20;
  localparam int SBT_N_MSB = 5;
  localparam int SBT_M_MSB = 11;
  localparam int SBT_M_LSB = 8;
  localparam int SBT_CHAR_MSB = 7;
  localparam int SBT_INT_TERM_BIT = 0;
  localparam logic [1:0] SBT_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBT_RESP_SLVERR = 2'h2;
  localparam logic [7:0] SBT_FLAG_PATTERN = 8'h7E;
  typedef enum logic [1:0] {
    SBT_MODE_HDLC = 2'b00,
    SBT_MODE_ASYNC = 2'b01,
    SBT_MODE_ISOCHR = 2'b10
  } sbt_mode_t;
  typedef struct packed {
    logic form_direct;
    logic [20:0] divisor;
  } sbt_baud_t;
  typedef struct packed {
    logic idle_flags;
    logic rx_crc_disable;
    logic tx_crc_off;
    logic rx_status_format;
    logic rx_threshold;
  } sbt_cfg2_t;
endpackage

// File: tb_top.sv
// tb_top: self-checking bench for sbt_channel over AXI4-Lite
// assumes the line model supplies clock-source edges and rx characters
module tb_top
  import sbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, tick_en = 0, tx_busy = 0;
  logic aw_r, w_r, ar_r, bv, rv, tick, rxv, brg, be, idl, rxc, txc, irq;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp;
  logic [7:0] rxd;
  sbt_mode_t mode = SBT_MODE_ASYNC;
  sbt_cfg2_t cfg2;
  int fail_count = 0, checks = 0, nblk = 0, cnt = 0;
  logic [31:0] rq[$];
  logic [1:0] bq[$];
  logic [1:0] rrq[$];
  int kq[$];
  always #5 mclk = ~mclk;
  sbt_channel u_dut (.mclk, .rst, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .clk_src_tick(tick), .op_mode(mode),
    .rx_char(rxd), .rx_char_valid(rxv), .tx_busy, .brg_tick(brg), .rx_block_end(be), .idle_line(idl),
    .rx_crc_check(rxc), .tx_crc_append(txc), .cfg2_out(cfg2), .irq);
  sbt_line_model u_line (.mclk, .tick_en, .clk_src_tick(tick), .rx_char(rxd), .rx_char_valid(rxv));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    if (bv && br)
      chk(bresp, bq.pop_front());
    if (rv && rr)
    begin
      chk(rd, rq.pop_front());
      chk(rresp, rrq.pop_front());
    end
    if (brg && kq.size() > 0)
      chk(cnt, kq.pop_front());
    cnt = brg ? tick : cnt + tick;
    if (be)
      nblk++;
  end
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = SBT_RESP_OKAY);
    bq.push_back(r);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do
    begin
      @(posedge mclk);
      if (aw_r)
        awv <= 0;
      if (w_r)
        wv <= 0;
    end while (!bv);
    br <= 0;
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = SBT_RESP_OKAY);
    rq.push_back(d);
    rrq.push_back(r);
    @(posedge mclk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do
    begin
      @(posedge mclk);
      if (ar_r)
        arv <= 0;
    end while (!rv);
    rr <= 0;
  endtask
  task automatic wbrg();
    do
      @(posedge mclk);
    while (!brg);
  endtask
  initial
  begin
    logic [11:0] ofs[3] = '{SBT_OFF_BAUD, SBT_OFF_TERM, SBT_OFF_CFG2};
    logic [31:0] wm[3] = '{SBT_BAUD_WMASK, SBT_TERM_WMASK, SBT_CFG2_WMASK};
    logic [31:0] tv[5] = '{32'h80000000, 32'h00000102, 32'h80000009, 32'h0000003F, 32'h0};
    logic [31:0] v;
    logic [7:0] b;
    sbt_mode_t md[6] = '{SBT_MODE_ASYNC, SBT_MODE_ASYNC, SBT_MODE_ISOCHR, SBT_MODE_HDLC, SBT_MODE_ASYNC, SBT_MODE_ASYNC};
    logic [7:0] ch[6] = '{8'h0D, 8'h0E, 8'h0D, 8'h0D, 8'h0D, 8'h0D};
    int k, n0, e;
    void'($urandom(58));
    repeat (12) @(posedge mclk);
    rst <= 0;
    foreach (ofs[i])
    begin
      axr(ofs[i], SBT_RESET_VAL);
      axw(ofs[i], 32'hFFFFFFFF);
      axr(ofs[i], wm[i]);
      if (i == 2)
        chk(cfg2, 5'h1F);
    end
    axw(12'h000, 32'h1, SBT_RESP_SLVERR);
    axr(12'h000, 32'h0, SBT_RESP_SLVERR);
    $display("test registers done");
    axw(SBT_OFF_BAUD, 32'h0);
    tick_en <= 1;
    tv[4] = ($urandom & 32'h80000307) | 32'h4;
    foreach (tv[i])
    begin
      wbrg();
      axw(SBT_OFF_BAUD, tv[i]);
      k = tv[i][31] ? tv[i][20:0] + 1 : (tv[i][5:0] + 1) << tv[i][11:8];
      wbrg();
      wbrg();
      #1 kq.push_back(k);
      wbrg();
    end
    $display("test divisor done");
    axw(SBT_OFF_BAUD, 32'h80000000);
    repeat (8)
    begin
      wbrg();
      b = {idl, b[7:1]};
    end
    e = 0;
    repeat (8)
    begin
      if (b == SBT_FLAG_PATTERN)
        e = 1;
      b = {b[0], b[7:1]};
    end
    chk(e, 1);
    // a busy transmitter owns the line, so no fill may leak out
    tx_busy <= 1;
    repeat (3) wbrg();
    chk(idl, 1'b1);
    tx_busy <= 0;
    axw(SBT_OFF_CFG2, 32'h0);
    repeat (3) wbrg();
    chk(idl, 1'b1);
    for (int j = 0; j < 4; j++)
    begin
      // one disable bit at a time so a swapped bit cannot pass
      mode <= (j == 3) ? SBT_MODE_ASYNC : SBT_MODE_HDLC;
      axw(SBT_OFF_CFG2, j[0] ? 32'h00400000 : {31'h0, j[1]});
      repeat (3) @(posedge mclk);
      chk({rxc, txc}, {!j[0], j < 2});
    end
    $display("test idle and crc done");
    for (int i = 0; i < 6; i++)
    begin
      mode <= md[i];
      axw(SBT_OFF_TERM, i == 4 ? 32'h0000000D : 32'h0000800D);
      axw(SBT_OFF_IMASK, i == 5);
      n0 = nblk;
      u_line.send_char(ch[i]);
      repeat (3) @(posedge mclk);
      e = (i == 0 || i == 2 || i == 5);
      chk(nblk - n0, e);
      chk(irq, e && i != 5);
      axr(SBT_OFF_ISTAT, e);
      axw(SBT_OFF_ISTAT, 32'h1);
      axr(SBT_OFF_ISTAT, 32'h0);
    end
    $display("test term char done");
    stop_test();
  end
  initial
  begin
    #300000;
    fail_count++;
    stop_test();
  end
endmodule
